// [frame_coalescer.sv]
`timescale 1ns/1ps
module frame_coalescer (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // events
  input wire logic frame_i,
  input wire logic tick_i,
  // thresholds
  input wire logic [7:0] count_thr_i,
  input wire logic [15:0] time_thr_i,
  // result
  output logic fire_o,
  output logic [7:0] pending_o
);
  import mac_ctl_pkg::*;

  logic [7:0] pend_q, pend_d;
  logic [15:0] timer_q, timer_d;
  logic fire_q, fire_d;
  logic [7:0] pend_inc;
  logic [7:0] thr_eff;
  wire count_hit;
  wire time_hit;

  // a zero count threshold behaves as one, so nothing is ever held forever
  assign thr_eff = (count_thr_i == 8'h00) ? 8'h01 : count_thr_i;
  assign pend_inc = frame_i ? pend_q + 8'h01 : pend_q;
  assign count_hit = frame_i && (pend_inc >= thr_eff);
  assign time_hit = (pend_q != 8'h00) && (time_thr_i != 16'h0000)
                    && tick_i && (timer_q + 16'h0001 >= time_thr_i);

  // timer runs only while frames are pending; a frame arriving on a
  // forced firing is folded into it rather than left stranded
  always_comb begin
    fire_d = count_hit || time_hit;
    pend_d = fire_d ? 8'h00 : pend_inc;
    timer_d = timer_q;
    if (fire_d || pend_inc == 8'h00) begin
      timer_d = 16'h0000;
    end else if (tick_i && pend_q != 8'h00) begin
      timer_d = timer_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_q <= 8'h00;
      timer_q <= 16'h0000;
      fire_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
      timer_q <= timer_d;
      fire_q <= fire_d;
    end
  end

  assign fire_o = fire_q;
  assign pending_o = pend_q;
endmodule

// [mac_ctl_asserts.sv]
`timescale 1ns/1ps
module mac_ctl_asserts #(
  parameter int FILL_W = 12
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // watched inputs
  input wire logic [FILL_W-1:0] tx_fill_i,
  input wire logic [FILL_W-1:0] rx_fill_i,
  input wire logic tx_frame_done_i,
  input wire logic da_valid_i,
  // watched outputs
  input wire logic da_hit_valid_o,
  input wire logic [31:0] tx_bd_addr_o,
  input mac_ctl_pkg::link_cfg_t link_cfg_o,
  input mac_ctl_pkg::prio_t prio_o,
  input wire logic pause_req_o
);
  import mac_ctl_pkg::*;
  // one domain, so clock and reset are given once
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_gig_full_dup: assert property (
    link_cfg_o.speed == SPD_1000 |-> link_cfg_o.full_dup)
    else $error("gigabit without full duplex");
  a_int_loop_mode: assert property (
    link_cfg_o.int_loop |-> link_cfg_o.if_mode inside {IF_MII, IF_GMII, IF_TBI})
    else $error("internal loopback in a reduced mode");
  a_starve_enter: assert property (
    (tx_fill_i <= TX_STARVE_ENTER) [*2] |=> prio_o.starve)
    else $error("starve not entered");
  a_starve_pri: assert property (
    prio_o.starve && !prio_o.emerg |-> prio_o.dma_pri == 2'h1 && prio_o.mac_pri == 2'h1)
    else $error("starve priorities wrong");
  a_starve_exit: assert property (
    (tx_fill_i >= TX_STARVE_EXIT) [*2] |=> !prio_o.starve)
    else $error("starve not cleared");
  a_starve_hold: assert property (
    tx_fill_i < TX_STARVE_EXIT ##1 prio_o.starve |=> prio_o.starve)
    else $error("starve dropped early");
  a_panic_level: assert property (
    (rx_fill_i >= RX_PANIC_LEVEL) [*2] |=> prio_o.panic && prio_o.mac_pri == 2'h1)
    else $error("panic not raised");
  a_emerg_pri: assert property (
    prio_o.emerg |-> prio_o.dma_pri == 2'h3)
    else $error("emergency dma priority not maximum");
  a_pause_entry: assert property (
    rx_fill_i >= RX_EMERG_LEVEL && $past(rx_fill_i) < RX_EMERG_LEVEL |=> pause_req_o)
    else $error("no pause on emergency entry");
  a_pause_once: assert property (
    pause_req_o |-> $past(rx_fill_i) >= RX_EMERG_LEVEL
    && ($past(rx_fill_i, 2) < RX_EMERG_LEVEL || $past(rst_i, 2)))
    else $error("pause without fresh entry");
  a_hash_answer: assert property (
    da_valid_i |=> da_hit_valid_o)
    else $error("hash lookup not answered");
  a_bd_advance: assert property (
    tx_frame_done_i |-> ##2 $changed(tx_bd_addr_o))
    else $error("descriptor address did not advance");
endmodule

bind tri_speed_mac_fifo_control mac_ctl_asserts #(.FILL_W(FILL_W)) i_mac_ctl_asserts (
  .clk_i(clk_i), .rst_i(rst_i), .tx_fill_i(tx_fill_i), .rx_fill_i(rx_fill_i),
  .tx_frame_done_i(tx_frame_done_i), .da_valid_i(da_valid_i),
  .da_hit_valid_o(da_hit_valid_o), .tx_bd_addr_o(tx_bd_addr_o),
  .link_cfg_o(link_cfg_o), .prio_o(prio_o), .pause_req_o(pause_req_o));

// [mac_ctl_pkg.sv]
// Contract
// - full and half duplex at 10 and 100
// - gigabit speed forces full duplex only
// - speed and interface mode set by configuration
// - internal loopback only with gmii, mii, tbi
// - external loopback done at the interface pins
// - 256-bit hash table filters destination addresses
// - tx fill within 512 bytes enters starve
// - starve clears once fill reaches 1 kbyte
// - rx fill at 1 kbyte raises mac priority
// - rx fill 1.5 kbytes: max dma, send pause
// - frame interrupts coalesced by frame count
// - coalescing timer forces stale pending interrupt
// - frames move via descriptors software prepares
package mac_ctl_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_EVENT = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h0c;
  localparam logic [7:0] OFS_TX_COAL = 8'h10;
  localparam logic [7:0] OFS_RX_COAL = 8'h14;
  localparam logic [7:0] OFS_TX_BD = 8'h18;
  localparam logic [7:0] OFS_RX_BD = 8'h1c;
  localparam logic [7:0] OFS_HASH = 8'h20;
  localparam int HASH_WORDS = 8;

  // fifo thresholds in bytes
  localparam logic [11:0] TX_STARVE_ENTER = 12'h200;
  localparam logic [11:0] TX_STARVE_EXIT = 12'h400;
  localparam logic [11:0] RX_PANIC_LEVEL = 12'h400;
  localparam logic [11:0] RX_EMERG_LEVEL = 12'h600;

  // descriptor stride in bytes
  localparam logic [31:0] BD_STRIDE = 32'h0000_0008;

  // event bit positions
  localparam int EV_TX_FRAME = 0;
  localparam int EV_RX_FRAME = 1;
  localparam int EV_STARVE = 2;
  localparam int EV_EMERG = 3;
  localparam int EV_WIDTH = 4;

  // reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] COAL_RESET = 32'h0000_0001;

  typedef enum logic [1:0] {
    SPD_10 = 2'b00,
    SPD_100 = 2'b01,
    SPD_1000 = 2'b10
  } speed_t;

  typedef enum logic [2:0] {
    IF_MII = 3'b000,
    IF_RMII = 3'b001,
    IF_GMII = 3'b010,
    IF_RGMII = 3'b011,
    IF_TBI = 3'b100,
    IF_RTBI = 3'b101
  } if_mode_t;

  // effective link configuration as seen by the datapath
  typedef struct packed {
    speed_t speed;
    logic full_dup;
    if_mode_t if_mode;
    logic int_loop;
    logic ext_loop;
  } link_cfg_t;

  // arbitration requests toward the coherency_arbiter
  typedef struct packed {
    logic starve;
    logic panic;
    logic emerg;
    logic [1:0] dma_pri;
    logic [1:0] mac_pri;
  } prio_t;

endpackage

// [phy_link_model.sv]
`timescale 1ns/1ps
module phy_link_model (
  // control
  input wire logic run_i,
  // link clock
  output logic link_clk_o
);
  // 400 ns clock; stands low while idle so stale edges never reach the timer
  initial begin
    link_clk_o = 1'b0;
    #7;
    forever begin
      #200;
      link_clk_o = run_i ? ~link_clk_o : 1'b0;
    end
  end
endmodule

// [test_tri_speed_mac_fifo_control.sv]
`timescale 1ns/1ps
module test_tri_speed_mac_fifo_control;
  import mac_ctl_pkg::*;
  typedef struct packed {logic [7:0] ctrl; link_cfg_t cfg;} row_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf, lanes = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, tx_bd_addr_o, rx_bd_addr_o, rd;
  logic link_clk_i, run = 1'b0, da_hit_o, da_hit_valid_o, pause_req_o, irq_o;
  logic [11:0] tx_fill_i = 12'h800, rx_fill_i = 12'h000;
  logic tx_frame_done_i = 1'b0, rx_frame_done_i = 1'b0, da_valid_i = 1'b0;
  logic [47:0] da_i = 48'h0;
  logic [7:0] idx;
  link_cfg_t link_cfg_o;
  prio_t prio_o;
  int errors = 0, n_compared = 0, n_pause = 0;
  // every interface mode once; reduced modes ask for loopback and must refuse it
  row_t rows [6] = '{
    '{8'h40, '{SPD_10, 1'b0, IF_MII, 1'b1, 1'b0}},
    '{8'h4d, '{SPD_100, 1'b1, IF_RMII, 1'b0, 1'b0}},
    '{8'h52, '{SPD_1000, 1'b1, IF_GMII, 1'b1, 1'b0}},
    '{8'hda, '{SPD_1000, 1'b1, IF_RGMII, 1'b0, 1'b1}},
    '{8'h60, '{SPD_10, 1'b0, IF_TBI, 1'b1, 1'b0}},
    '{8'he9, '{SPD_100, 1'b0, IF_RTBI, 1'b0, 1'b1}}};

  tri_speed_mac_fifo_control #(.RING_LEN(8), .FILL_W(12)) i_tri_speed_mac_fifo_control (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .link_clk_i(link_clk_i),
    .tx_fill_i(tx_fill_i), .rx_fill_i(rx_fill_i), .tx_frame_done_i(tx_frame_done_i),
    .rx_frame_done_i(rx_frame_done_i), .da_valid_i(da_valid_i), .da_i(da_i),
    .da_hit_o(da_hit_o), .da_hit_valid_o(da_hit_valid_o), .link_cfg_o(link_cfg_o),
    .prio_o(prio_o), .pause_req_o(pause_req_o), .tx_bd_addr_o(tx_bd_addr_o),
    .rx_bd_addr_o(rx_bd_addr_o), .irq_o(irq_o));
  phy_link_model i_phy_link_model (.run_i(run), .link_clk_o(link_clk_i));

  // clock and pause pulse counter
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) if (pause_req_o === 1'b1) n_pause <= n_pause + 1;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // one classic cycle; read data is taken at the ack edge only
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
    int n;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i} <= {2'b11, we, lanes, adr, wd};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    if (wb_ack_o !== 1'b1) begin
      errors++;
      close_out();
    end
  endtask
  task automatic frame(input logic rx);
    @(posedge clk_i);
    if (rx) rx_frame_done_i <= 1'b1; else tx_frame_done_i <= 1'b1;
    @(posedge clk_i);
    {rx_frame_done_i, tx_frame_done_i} <= 2'b00;
    tick(4);
  endtask
  task automatic fill(input logic rx, input logic [11:0] v);
    if (rx) rx_fill_i <= v; else tx_fill_i <= v;
    tick(4);
  endtask
  // crc over the address, lsb first, index from the top byte
  function automatic logic [7:0] crc_idx(input logic [47:0] d);
    logic [31:0] c;
    c = 32'hffff_ffff;
    for (int i = 0; i < 48; i++) c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? 32'h04c1_1db7 : 32'h0);
    return c[31:24];
  endfunction

  initial begin
    tick(20);
    rst_i <= 1'b0;
    wb(0, OFS_CTRL, 0); check(rd, CTRL_RESET);
    wb(0, OFS_TX_COAL, 0); check(rd, COAL_RESET);
    wb(0, OFS_TX_BD, 0); check(rd, 32'h0);
    wb(1, 8'h40, 32'hffff_ffff); wb(0, 8'h40, 0); check(rd, 32'h0);
    wb(0, OFS_EVENT, 0);
    $display("reset test done");
    for (int i = 0; i < 6; i++) begin
      wb(1, OFS_CTRL, {24'h0, rows[i].ctrl}); tick(3);
      check({24'h0, link_cfg_o}, {24'h0, rows[i].cfg});
    end
    lanes = 4'h0; wb(1, OFS_CTRL, 32'hff); lanes = 4'hf; tick(3);
    check({24'h0, link_cfg_o}, {24'h0, rows[5].cfg});
    $display("configuration test done");
    // tx watermarks with the interrupt masked off
    fill(0, 12'h201); check({25'h0, prio_o}, 32'h0);
    fill(0, 12'h200); check({25'h0, prio_o}, 32'h45); check(irq_o, 0);
    fill(0, 12'h3ff); check({25'h0, prio_o}, 32'h45);
    fill(0, 12'h400); check({25'h0, prio_o}, 32'h0);
    wb(0, OFS_EVENT, 0); check(rd, 32'h4);
    // rx watermarks, emergency unmasked
    wb(1, OFS_MASK, 32'h8);
    fill(1, 12'h3ff); check({25'h0, prio_o}, 32'h0);
    fill(1, 12'h400); check({25'h0, prio_o}, 32'h21);
    fill(1, 12'h600); check({25'h0, prio_o}, 32'h3d); check(irq_o, 1);
    wb(0, OFS_STATUS, 0); check(rd, 32'h68);
    tick(10); check(n_pause, 1);
    fill(1, 12'h5ff); check(n_pause, 1);
    fill(1, 12'h600); check(n_pause, 2);
    wb(0, OFS_EVENT, 0); check(rd, 32'h8); tick(3); check(irq_o, 0);
    fill(1, 12'h000);
    $display("watermark test done");
    // frame count coalescing and descriptor ring walk
    wb(1, OFS_TX_BD, 32'h1000); tick(3); check(tx_bd_addr_o, 32'h1000);
    wb(1, OFS_TX_COAL, 32'h2);
    frame(0); wb(0, OFS_EVENT, 0); check(rd, 32'h0);
    check(tx_bd_addr_o, 32'h1008);
    frame(0); wb(0, OFS_EVENT, 0); check(rd, 32'h1);
    for (int i = 0; i < 6; i++) frame(0);
    check(tx_bd_addr_o, 32'h1000);
    wb(0, OFS_EVENT, 0);
    // timer forces a stale rx interrupt
    wb(1, OFS_RX_COAL, 32'h0304); run <= 1'b1;
    frame(1); wb(0, OFS_EVENT, 0); check(rd, 32'h0);
    tick(90); wb(0, OFS_EVENT, 0); check(rd, 32'h2);
    run <= 1'b0;
    check(rx_bd_addr_o, 32'h8);
    $display("coalescing test done");
    // hash hit on the programmed bit, miss elsewhere
    idx = crc_idx(48'h0102_0304_0506);
    wb(1, OFS_HASH + {idx[7:5], 2'b00}, 32'h1 << idx[4:0]);
    for (int i = 0; i < 2; i++) begin
      da_i <= i ? 48'h0a0b_0c0d_0e0f : 48'h0102_0304_0506; da_valid_i <= 1'b1;
      @(posedge clk_i); da_valid_i <= 1'b0; @(posedge clk_i);
      check({da_hit_valid_o, da_hit_o}, {1'b1, crc_idx(da_i) == idx});
    end
    $display("hash test done");
    close_out();
  end
endmodule

// [tri_speed_mac_fifo_control.sv]
`timescale 1ns/1ps
module tri_speed_mac_fifo_control #(
  parameter int RING_LEN = 8,
  parameter int FILL_W = 12
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // link clock from the phy, sampled
  input wire logic link_clk_i,
  // fifo fill levels in bytes, same clock
  input wire logic [FILL_W-1:0] tx_fill_i,
  input wire logic [FILL_W-1:0] rx_fill_i,
  // frame completion pulses, same clock
  input wire logic tx_frame_done_i,
  input wire logic rx_frame_done_i,
  // received destination address
  input wire logic da_valid_i,
  input wire logic [47:0] da_i,
  output logic da_hit_o,
  output logic da_hit_valid_o,
  // configuration and priority outputs
  output mac_ctl_pkg::link_cfg_t link_cfg_o,
  output mac_ctl_pkg::prio_t prio_o,
  output logic pause_req_o,
  // descriptor addresses for the dma
  output logic [31:0] tx_bd_addr_o,
  output logic [31:0] rx_bd_addr_o,
  // interrupt
  output logic irq_o
);
  import mac_ctl_pkg::*;

  localparam int IDX_W = (RING_LEN > 1) ? $clog2(RING_LEN) : 1;

  // crc-32 of the address, top byte picks one of 256 hash bits
  function automatic logic [7:0] hash_index(input logic [47:0] addr);
    logic [31:0] crc;
    logic fb;
    crc = 32'hffff_ffff;
    for (int i = 0; i < 48; i++) begin
      fb = crc[31] ^ addr[i];
      crc = {crc[30:0], 1'b0};
      if (fb) begin
        crc = crc ^ 32'h04c1_1db7;
      end
    end
    return crc[31:24];
  endfunction

  // configuration is legal only in a few combinations
  function automatic logic loop_capable(input if_mode_t m);
    return (m == IF_GMII) || (m == IF_MII) || (m == IF_TBI);
  endfunction

  // ---------------------------------------------------------------
  // registers
  logic [31:0] ctrl_q;
  logic [EV_WIDTH-1:0] event_q, event_d;
  logic [EV_WIDTH-1:0] mask_q;
  logic [31:0] tx_coal_q, rx_coal_q;
  logic [31:0] tx_bd_base_q, rx_bd_base_q;
  logic [31:0] hash_q [HASH_WORDS];
  logic [31:0] rdata_q;
  logic ack_q;
  logic irq_q;

  // bus decode
  wire req = wb_cyc_i && wb_stb_i;
  wire wr_now = req && ack_q && wb_we_i;
  wire rd_now = req && ack_q && !wb_we_i;
  wire hash_sel = (wb_adr_i[7:5] == OFS_HASH[7:5]);
  wire [2:0] hash_word = wb_adr_i[4:2];

  // byte-lane merge of write data into an existing word
  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // effective link configuration
  speed_t cfg_speed;
  if_mode_t cfg_mode;
  link_cfg_t cfg_d;
  link_cfg_t cfg_q;
  assign cfg_speed = speed_t'(ctrl_q[1:0]);
  assign cfg_mode = if_mode_t'(ctrl_q[5:3]);
  assign cfg_d.speed = cfg_speed;
  assign cfg_d.if_mode = cfg_mode;
  // half duplex honoured at 10 and 100, refused at gigabit
  assign cfg_d.full_dup = (cfg_speed == SPD_1000) ? 1'b1 : ctrl_q[2];
  assign cfg_d.int_loop = ctrl_q[6] && loop_capable(cfg_mode);
  assign cfg_d.ext_loop = ctrl_q[7];

  // ---------------------------------------------------------------
  // link clock sampling: three stages, change taken when 2nd and 3rd agree
  logic lk1_q, lk2_q, lk3_q, lk_stable_q, link_tick_q;
  wire lk_agree = (lk2_q == lk3_q);
  wire lk_rise = lk_agree && lk3_q && !lk_stable_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lk1_q <= 1'b0;
      lk2_q <= 1'b0;
      lk3_q <= 1'b0;
      lk_stable_q <= 1'b0;
      link_tick_q <= 1'b0;
    end else begin
      lk1_q <= link_clk_i;
      lk2_q <= lk1_q;
      lk3_q <= lk2_q;
      if (lk_agree) begin
        lk_stable_q <= lk3_q;
      end
      link_tick_q <= lk_rise;
    end
  end

  // ---------------------------------------------------------------
  // fifo watermarks with hysteresis on the transmit side
  logic starve_q, panic_q, emerg_q, pause_q;
  prio_t prio_q;
  wire [11:0] txf = 12'(tx_fill_i);
  wire [11:0] rxf = 12'(rx_fill_i);
  wire starve_set = !starve_q && (txf <= TX_STARVE_ENTER);
  wire starve_clr = starve_q && (txf >= TX_STARVE_EXIT);
  wire panic_now = (rxf >= RX_PANIC_LEVEL);
  wire emerg_now = (rxf >= RX_EMERG_LEVEL);
  // pause issued only on entry; staying above the level sends nothing more
  wire emerg_entry = emerg_now && !emerg_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      starve_q <= 1'b0;
      panic_q <= 1'b0;
      emerg_q <= 1'b0;
      pause_q <= 1'b0;
    end else begin
      if (starve_set) begin
        starve_q <= 1'b1;
      end else if (starve_clr) begin
        starve_q <= 1'b0;
      end
      panic_q <= panic_now;
      emerg_q <= emerg_now;
      pause_q <= emerg_entry;
    end
  end

  // priority encoding: 0 normal, 1 raised, 3 maximum
  prio_t prio_d;
  assign prio_d.starve = starve_q;
  assign prio_d.panic = panic_q;
  assign prio_d.emerg = emerg_q;
  assign prio_d.dma_pri = emerg_q ? 2'h3 : (starve_q ? 2'h1 : 2'h0);
  assign prio_d.mac_pri = (starve_q || panic_q || emerg_q) ? 2'h1 : 2'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prio_q <= '0;
      cfg_q <= '0;
    end else begin
      prio_q <= prio_d;
      cfg_q <= cfg_d;
    end
  end

  // ---------------------------------------------------------------
  // interrupt coalescing, timer counted in link clock cycles
  logic tx_fire, rx_fire;
  logic [7:0] tx_pend, rx_pend;

  frame_coalescer u_tx_coal (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .frame_i(tx_frame_done_i),
    .tick_i(link_tick_q),
    .count_thr_i(tx_coal_q[7:0]),
    .time_thr_i(tx_coal_q[23:8]),
    .fire_o(tx_fire),
    .pending_o(tx_pend)
  );

  frame_coalescer u_rx_coal (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .frame_i(rx_frame_done_i),
    .tick_i(link_tick_q),
    .count_thr_i(rx_coal_q[7:0]),
    .time_thr_i(rx_coal_q[23:8]),
    .fire_o(rx_fire),
    .pending_o(rx_pend)
  );

  // ---------------------------------------------------------------
  // descriptor ring walk: one descriptor consumed per finished frame
  logic [IDX_W-1:0] tx_idx_q, rx_idx_q;
  logic [31:0] tx_bd_q, rx_bd_q;
  wire [IDX_W-1:0] idx_last = IDX_W'(RING_LEN - 1);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_idx_q <= '0;
      rx_idx_q <= '0;
      tx_bd_q <= 32'h0000_0000;
      rx_bd_q <= 32'h0000_0000;
    end else begin
      if (tx_frame_done_i) begin
        tx_idx_q <= (tx_idx_q == idx_last) ? '0 : tx_idx_q + 1'b1;
      end
      if (rx_frame_done_i) begin
        rx_idx_q <= (rx_idx_q == idx_last) ? '0 : rx_idx_q + 1'b1;
      end
      tx_bd_q <= tx_bd_base_q + 32'(tx_idx_q) * BD_STRIDE;
      rx_bd_q <= rx_bd_base_q + 32'(rx_idx_q) * BD_STRIDE;
    end
  end

  // ---------------------------------------------------------------
  // destination hash lookup, answered one cycle after the address
  wire [7:0] hidx = hash_index(da_i);
  logic hit_q, hit_vld_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hit_q <= 1'b0;
      hit_vld_q <= 1'b0;
    end else begin
      hit_vld_q <= da_valid_i;
      hit_q <= da_valid_i && hash_q[hidx[7:5]][hidx[4:0]];
    end
  end

  // ---------------------------------------------------------------
  // sticky events; the read clears only the bits it returned, so an event
  // that lands while the read is in flight is never lost
  logic [EV_WIDTH-1:0] ev_new;
  wire ev_clear = rd_now && (wb_adr_i == OFS_EVENT);
  assign ev_new[EV_TX_FRAME] = tx_fire;
  assign ev_new[EV_RX_FRAME] = rx_fire;
  assign ev_new[EV_STARVE] = starve_set;
  assign ev_new[EV_EMERG] = emerg_entry;
  assign event_d = (ev_clear ? (event_q & ~rdata_q[EV_WIDTH-1:0]) : event_q) | ev_new;

  // ---------------------------------------------------------------
  // read mux, registered so data is valid with ack
  logic [31:0] status_word;
  logic [31:0] rmux;
  assign status_word = {8'h00, rx_pend, tx_pend, 1'b0, emerg_q, panic_q, starve_q,
                        cfg_q.ext_loop, cfg_q.int_loop, cfg_q.full_dup, 1'b0};

  always_comb begin
    rmux = 32'h0000_0000;
    if (hash_sel) begin
      rmux = hash_q[hash_word];
    end else begin
      case (wb_adr_i)
        OFS_CTRL: rmux = ctrl_q;
        OFS_STATUS: rmux = status_word;
        OFS_EVENT: rmux = 32'(event_q);
        OFS_MASK: rmux = 32'(mask_q);
        OFS_TX_COAL: rmux = tx_coal_q;
        OFS_RX_COAL: rmux = rx_coal_q;
        OFS_TX_BD: rmux = tx_bd_base_q;
        OFS_RX_BD: rmux = rx_bd_base_q;
        default: rmux = 32'h0000_0000;
      endcase
    end
  end

  // ack one cycle after the request; write lands on the acked edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= req && !ack_q;
      rdata_q <= rmux;
    end
  end

  // mask merged as a full word, then cut to the event width
  wire [31:0] mask_wr = lane_merge(32'(mask_q), wb_dat_i, wb_sel_i);

  // writable registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RESET;
      mask_q <= '0;
      tx_coal_q <= COAL_RESET;
      rx_coal_q <= COAL_RESET;
      tx_bd_base_q <= 32'h0000_0000;
      rx_bd_base_q <= 32'h0000_0000;
    end else if (wr_now) begin
      case (wb_adr_i)
        OFS_CTRL: ctrl_q <= lane_merge(ctrl_q, wb_dat_i, wb_sel_i);
        OFS_MASK: mask_q <= mask_wr[EV_WIDTH-1:0];
        OFS_TX_COAL: tx_coal_q <= lane_merge(tx_coal_q, wb_dat_i, wb_sel_i);
        OFS_RX_COAL: rx_coal_q <= lane_merge(rx_coal_q, wb_dat_i, wb_sel_i);
        OFS_TX_BD: tx_bd_base_q <= lane_merge(tx_bd_base_q, wb_dat_i, wb_sel_i);
        OFS_RX_BD: rx_bd_base_q <= lane_merge(rx_bd_base_q, wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end
  end

  // hash table words, one per generate slot
  genvar g;
  generate
    for (g = 0; g < HASH_WORDS; g++) begin : g_hash
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          hash_q[g] <= 32'h0000_0000;
        end else if (wr_now && hash_sel && hash_word == 3'(g)) begin
          hash_q[g] <= lane_merge(hash_q[g], wb_dat_i, wb_sel_i);
        end
      end
    end
  endgenerate

  // event register and level interrupt
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      event_q <= '0;
      irq_q <= 1'b0;
    end else begin
      event_q <= event_d;
      irq_q <= |(event_d & mask_q);
    end
  end

  // outputs straight from flip-flops
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;
  assign da_hit_o = hit_q;
  assign da_hit_valid_o = hit_vld_q;
  assign link_cfg_o = cfg_q;
  assign prio_o = prio_q;
  assign pause_req_o = pause_q;
  assign tx_bd_addr_o = tx_bd_q;
  assign rx_bd_addr_o = rx_bd_q;
  assign irq_o = irq_q;
endmodule
